// ===== verilog/pseirq_event_logic.sv
// Purpose: per-channel event flags, summary and interrupt pin
// Assumes: all inputs except nrst synchronous to ref_clk
// Notes: the general mask bits and the other summary sources
//        arrive as plain inputs
//
// Contract
// - power-enable summary is OR of channel flags
// - mask register read/write, zero blocks interrupt
// - summary bits track events regardless of mask
// - interrupt also needs global enable set
// - mask layout; only supply mask resets high
// - power events: plain read, clearing read
// - power-good upper nibble, enable lower nibble
// - clearing read clears every register bit
// - clearing read releases interrupt it caused
// - any event bit sets its summary bit
// - one bit per channel, active high
// - four-pair enable flags stay per channel
// - single-signature four-pair power-good waits both channels
// - dual-signature flags set per channel
// - discovery events: two codes, cleared on off
// - upper discovery nibble: classification or change
// - lower discovery nibble: detection or change
// - summary clears by source read or reset
`timescale 1ns/1ns
`include "pseirq_defs.svh"

module pseirq_event_logic
   import pseirq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // channel status from the port state machines
   input wire pseirq_chan_t chan_status,
   // port wiring: index 0 is channels 1-2, index 1 is 3-4
   input wire logic [1:0] port_four_pair,
   input wire logic [1:0] port_single_sig,
   // general mask bits held elsewhere
   input wire logic global_irq_enable,
   input wire logic class_change_only_en,
   input wire logic detect_change_only_en,
   // summary clear from bit 7 of the reset register
   input wire logic summary_clear_all,
   // summary sources kept outside this block
   input wire logic supply_fault_any,
   input wire logic start_fault_any,
   input wire logic overload_fault_any,
   input wire logic disconnect_any,
   // host command port
   input wire pseirq_cmd_t cmd,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // interrupt pin, active low
   output logic irq_n
);

   // ========================================================
   // state
   localparam pseirq_state_t RST_STATE = '{
      interrupt_event_mask: `PSEIRQ_MASK_RST,
      power_change_events: `PSEIRQ_EVENT_RST,
      discovery_events: `PSEIRQ_EVENT_RST,
      pg_pending: `PSEIRQ_NIBBLE_RST,
      rd_data: `PSEIRQ_EVENT_RST,
      rd_valid: 1'b0,
      irq_n: 1'b1
   };

   pseirq_state_t s_q;
   pseirq_state_t s_d;

   // ========================================================
   // combinational helpers
   logic [3:0] pe_set;
   logic [3:0] pg_set;
   logic [3:0] det_set;
   logic [3:0] cls_set;
   logic [3:0] pend_next;
   logic [7:0] summary_q;
   logic [7:0] summary_d;
   logic rd_cmd;
   logic wr_cmd;

   // summary from the event state; used for reads
   function automatic logic [7:0] make_summary(
      input logic [7:0] pwr,
      input logic [7:0] disc
   );
      logic [7:0] v;
      v = '0;
      v[`PSEIRQ_BIT_SUPPLY] = supply_fault_any;
      v[`PSEIRQ_BIT_START] = start_fault_any;
      v[`PSEIRQ_BIT_OVERLOAD] = overload_fault_any;
      v[`PSEIRQ_BIT_DISCONNECT] = disconnect_any;
      v[`PSEIRQ_BIT_CLASSIFY] = |disc[`PSEIRQ_HI_LSB +: 4];
      v[`PSEIRQ_BIT_DETECT] = |disc[`PSEIRQ_LO_LSB +: 4];
      v[`PSEIRQ_BIT_POWER_GOOD] = |pwr[`PSEIRQ_HI_LSB +: 4];
      v[`PSEIRQ_BIT_POWER_ENABLE] = |pwr[`PSEIRQ_LO_LSB +: 4];
      return v;
   endfunction : make_summary

   always_comb
   begin
      s_d = s_q;
      rd_cmd = cmd.valid && !cmd.write;
      wr_cmd = cmd.valid && cmd.write;

      // ------------------------------------------------------
      // per-channel set terms, one bit per channel
      // enable-change flags are always per channel, even
      // on four-pair ports of either signature type
      pe_set = chan_status.power_enable_chg;

      // classification: cycle done or class change
      if (class_change_only_en)
      begin
         cls_set = chan_status.class_result_chg;
      end
      else
      begin
         cls_set = chan_status.classify_done;
      end

      // detection: cycle done or result change
      if (detect_change_only_en)
      begin
         det_set = chan_status.detect_result_chg;
      end
      else
      begin
         det_set = chan_status.detect_done;
      end

      // ------------------------------------------------------
      // power-good: a single-signature four-pair port holds
      // each channel's change until its partner has changed
      // too, then flags both at once so the host sees one
      // interrupt instead of two in quick succession
      pg_set = '0;
      pend_next = s_q.pg_pending;
      for (int p = 0; p < 2; p++)
      begin
         if (port_four_pair[p] && port_single_sig[p])
         begin
            pend_next[2*p] = s_q.pg_pending[2*p]
               | chan_status.power_good_chg[2*p];
            pend_next[2*p+1] = s_q.pg_pending[2*p+1]
               | chan_status.power_good_chg[2*p+1];
            if (pend_next[2*p] && pend_next[2*p+1])
            begin
               pg_set[2*p] = 1'b1;
               pg_set[2*p+1] = 1'b1;
               pend_next[2*p] = 1'b0;
               pend_next[2*p+1] = 1'b0;
            end
         end
         else
         begin
            // dual signature or two-pair: flag as it happens
            pg_set[2*p] = chan_status.power_good_chg[2*p];
            pg_set[2*p+1] =
               chan_status.power_good_chg[2*p+1];
            pend_next[2*p] = 1'b0;
            pend_next[2*p+1] = 1'b0;
         end
      end
      s_d.pg_pending = pend_next;

      // ------------------------------------------------------
      // read data is the value before any clear
      s_d.rd_valid = rd_cmd;
      if (rd_cmd)
      begin
         summary_q = make_summary(s_q.power_change_events,
            s_q.discovery_events);
         unique case (cmd.code)
            `PSEIRQ_CMD_SUMMARY:
               s_d.rd_data = summary_q;
            `PSEIRQ_CMD_MASK:
               s_d.rd_data = s_q.interrupt_event_mask;
            `PSEIRQ_CMD_PWR, `PSEIRQ_CMD_PWR_CLR:
               s_d.rd_data = s_q.power_change_events;
            `PSEIRQ_CMD_DISC, `PSEIRQ_CMD_DISC_CLR:
               s_d.rd_data = s_q.discovery_events;
            default:
               s_d.rd_data = `PSEIRQ_EVENT_RST;
         endcase
      end
      else
      begin
         summary_q = '0;
      end

      // ------------------------------------------------------
      // mask register; writes elsewhere are ignored
      if (wr_cmd && cmd.code == `PSEIRQ_CMD_MASK)
      begin
         s_d.interrupt_event_mask = cmd.wdata;
      end

      // ------------------------------------------------------
      // power events: a clearing read or the summary clear
      // wipes the whole register, but a change arriving in
      // the same cycle still lands
      if ((rd_cmd && cmd.code == `PSEIRQ_CMD_PWR_CLR)
         || summary_clear_all)
      begin
         s_d.power_change_events = `PSEIRQ_EVENT_RST;
      end
      s_d.power_change_events[`PSEIRQ_HI_LSB +: 4] =
         s_d.power_change_events[`PSEIRQ_HI_LSB +: 4]
         | pg_set;
      s_d.power_change_events[`PSEIRQ_LO_LSB +: 4] =
         s_d.power_change_events[`PSEIRQ_LO_LSB +: 4]
         | pe_set;

      // ------------------------------------------------------
      // discovery events: also dropped per channel when the
      // channel is turned off
      if ((rd_cmd && cmd.code == `PSEIRQ_CMD_DISC_CLR)
         || summary_clear_all)
      begin
         s_d.discovery_events = `PSEIRQ_EVENT_RST;
      end
      s_d.discovery_events[`PSEIRQ_HI_LSB +: 4] =
         (s_d.discovery_events[`PSEIRQ_HI_LSB +: 4]
         & ~chan_status.chan_off) | cls_set;
      s_d.discovery_events[`PSEIRQ_LO_LSB +: 4] =
         (s_d.discovery_events[`PSEIRQ_LO_LSB +: 4]
         & ~chan_status.chan_off) | det_set;

      // ------------------------------------------------------
      // pin follows the next summary so that a clearing
      // read releases it on the same edge as the clear;
      // the summary itself ignores the mask
      summary_d = make_summary(s_d.power_change_events,
         s_d.discovery_events);
      s_d.irq_n = !(global_irq_enable
         && |(summary_d & s_d.interrupt_event_mask));
   end

   // ========================================================
   // the only register process
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_q <= RST_STATE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ========================================================
   // outputs straight from the state flops
   assign rd_data = s_q.rd_data;
   assign rd_valid = s_q.rd_valid;
   assign irq_n = s_q.irq_n;

endmodule : pseirq_event_logic

// ===== verilog/pseirq_defs.svh
// Purpose: constants of the event and interrupt logic
// Assumes: command codes are eight bits wide
// Notes: definitions only
`ifndef PSEIRQ_DEFS_SVH
`define PSEIRQ_DEFS_SVH

// ==========================================================
// command codes
`define PSEIRQ_CMD_SUMMARY 8'h00
`define PSEIRQ_CMD_MASK 8'h01
`define PSEIRQ_CMD_PWR 8'h02
`define PSEIRQ_CMD_PWR_CLR 8'h03
`define PSEIRQ_CMD_DISC 8'h04
`define PSEIRQ_CMD_DISC_CLR 8'h05

// ==========================================================
// summary and mask bit positions
`define PSEIRQ_BIT_SUPPLY 7
`define PSEIRQ_BIT_START 6
`define PSEIRQ_BIT_OVERLOAD 5
`define PSEIRQ_BIT_CLASSIFY 4
`define PSEIRQ_BIT_DETECT 3
`define PSEIRQ_BIT_DISCONNECT 2
`define PSEIRQ_BIT_POWER_GOOD 1
`define PSEIRQ_BIT_POWER_ENABLE 0

// ==========================================================
// event register field positions (upper and lower nibble)
`define PSEIRQ_HI_LSB 4
`define PSEIRQ_LO_LSB 0

// ==========================================================
// reset values
`define PSEIRQ_MASK_RST 8'h80
`define PSEIRQ_EVENT_RST 8'h00
`define PSEIRQ_NIBBLE_RST 4'h0

`endif

// ===== verilog/pseirq_pkg.sv
// Purpose: types of the event and interrupt logic
// Assumes: four channels, paired 1-2 and 3-4 into ports
// Notes: state is one packed struct
package pseirq_pkg;

   // =======================================================
   // per-channel status inputs, one bit per channel
   typedef struct packed {
      logic [3:0] power_enable_chg;
      logic [3:0] power_good_chg;
      logic [3:0] detect_done;
      logic [3:0] detect_result_chg;
      logic [3:0] classify_done;
      logic [3:0] class_result_chg;
      logic [3:0] chan_off;
   } pseirq_chan_t;

   // =======================================================
   // host command port
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [7:0] wdata;
   } pseirq_cmd_t;

   // =======================================================
   // complete register state
   typedef struct packed {
      logic [7:0] interrupt_event_mask;
      logic [7:0] power_change_events;
      logic [7:0] discovery_events;
      logic [3:0] pg_pending;
      logic [7:0] rd_data;
      logic rd_valid;
      logic irq_n;
   } pseirq_state_t;

endpackage : pseirq_pkg

// ===== testbench/pseirq_properties.sv
// Purpose: port assertions of the event and interrupt logic
// Assumes: one clock domain, nrst asynchronous active low
// Notes: bound to the top module, sees its ports only
`timescale 1ns/1ns
module pseirq_checker
   import pseirq_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // watched inputs
   input wire pseirq_chan_t chan_status,
   input wire logic [1:0] port_four_pair,
   input wire logic global_irq_enable,
   input wire logic supply_fault_any,
   input wire pseirq_cmd_t cmd,
   // watched outputs
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic irq_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic rd;
   assign rd = cmd.valid && !cmd.write;
   // =====
   // assertions
   AST_RD_ONE:
      assert property (rd |=> rd_valid) else $error("read not answered");
   AST_RD_NONE:
      assert property (!rd |=> !rd_valid) else $error("stray rd_valid");
   AST_MASK_RW:
      assert property ((cmd.valid && cmd.write && cmd.code == 8'h01)
         ##1 !cmd.valid ##1 (rd && cmd.code == 8'h01)
         |=> rd_data == $past(cmd.wdata, 3)) else $error("mask readback");
   AST_NO_EN:
      assert property (!global_irq_enable |=> irq_n)
         else $error("irq without enable");
   AST_PE_SEEN:
      assert property ((chan_status.power_enable_chg != 4'h0)
         ##1 (rd && (cmd.code == 8'h02 || cmd.code == 8'h03))
         |=> (rd_data[3:0]
         & $past(chan_status.power_enable_chg, 2))
         == $past(chan_status.power_enable_chg, 2)) else $error("pe flag");
   AST_PG_SEEN:
      assert property ((port_four_pair == 2'b00
         && chan_status.power_good_chg != 4'h0)
         ##1 (rd && cmd.code == 8'h02) |=> (rd_data[7:4]
         & $past(chan_status.power_good_chg, 2))
         == $past(chan_status.power_good_chg, 2)) else $error("pg flag");
   AST_CLR_ALL:
      assert property ((rd && cmd.code == 8'h03
         && chan_status[27:20] == 8'h00)
         ##1 (chan_status[27:20] == 8'h00) ##1 (rd && cmd.code == 8'h02)
         |=> rd_data == 8'h00) else $error("clearing read left bits");
   AST_SUM_PASS:
      assert property ((rd && cmd.code == 8'h00)
         |=> rd_data[7] == $past(supply_fault_any)) else $error("summary");
   cover property (!irq_n);
   cover property (rd && cmd.code == 8'h03);
   cover property (chan_status.power_good_chg != 4'h0 && port_four_pair[0]);
endmodule : pseirq_checker

bind pseirq_event_logic pseirq_checker pseirq_checker_inst (
   .ref_clk(ref_clk), .nrst(nrst), .chan_status(chan_status),
   .port_four_pair(port_four_pair), .global_irq_enable(global_irq_enable),
   .supply_fault_any(supply_fault_any), .cmd(cmd), .rd_data(rd_data),
   .rd_valid(rd_valid), .irq_n(irq_n));

// ===== testbench/pseirq_host_model.sv
// Purpose: host side of the command port
// Assumes: called at a falling edge of ref_clk
// Notes: idle fields carry inverted values so stale data is not trusted
`timescale 1ns/1ns
module pseirq_host_model
   import pseirq_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // command port
   output pseirq_cmd_t cmd,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   initial cmd = '0;
   // =====
   // one command; ok stays low when a read gets no answer
   task xfer(input logic w, input logic [7:0] c, input logic [7:0] wd,
      output logic [7:0] d, output logic ok);
      cmd = '{1'b1, w, c, wd};
      @(negedge ref_clk);
      cmd = '{1'b0, ~w, ~c, ~wd};
      ok = w;
      d = 8'h00;
      for (int n = 0; n < 4 && !ok; n++)
      begin
         if (rd_valid === 1'b1)
         begin
            ok = 1'b1;
            d = rd_data;
         end
         else
            @(negedge ref_clk);
      end
      @(negedge ref_clk);
   endtask : xfer
endmodule : pseirq_host_model

// ===== testbench/tb.sv
// Purpose: self-checking bench of the event and interrupt logic
// Assumes: inputs change at falling edges only
// Notes: channel pulses from the bench, commands from the host model
`timescale 1ns/1ns
module tb;
   import pseirq_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   pseirq_chan_t cs = '0;
   logic [1:0] fp = '0, ss = '0;
   logic gen = 1'b0, cce = 1'b0, dce = 1'b0, clr = 1'b0, ok;
   logic [3:0] flt = '0, b;
   pseirq_cmd_t cmd;
   logic [7:0] rd_data, v, m;
   logic rd_valid, irq_n;
   int seed = 41, mismatches = 0, checked = 0;
   always #2 ref_clk = ~ref_clk;
   pseirq_event_logic pseirq_event_logic_inst (
      .ref_clk(ref_clk), .nrst(nrst), .chan_status(cs),
      .port_four_pair(fp), .port_single_sig(ss), .global_irq_enable(gen),
      .class_change_only_en(cce), .detect_change_only_en(dce),
      .summary_clear_all(clr), .supply_fault_any(flt[3]),
      .start_fault_any(flt[2]), .overload_fault_any(flt[1]),
      .disconnect_any(flt[0]), .cmd(cmd), .rd_data(rd_data),
      .rd_valid(rd_valid), .irq_n(irq_n));
   pseirq_host_model pseirq_host_model_inst (.ref_clk(ref_clk), .cmd(cmd),
      .rd_data(rd_data), .rd_valid(rd_valid));
   // =====
   // helpers
   task end_sim;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task xf(input logic w, input logic [7:0] c, input logic [7:0] wd);
      pseirq_host_model_inst.xfer(w, c, wd, v, ok);
      if (!ok)
      begin
         mismatches++;
         end_sim();
      end
   endtask : xf
   task rx(input logic [7:0] c, input logic [7:0] e);
      xf(1'b0, c, 8'h00);
      chk("rd_data", e, v);
   endtask : rx
   // f selects the field: pe, pg, det, det chg, cls, cls chg, off
   task pls(input int f, input logic [3:0] p);
      cs = pseirq_chan_t'(28'(p) << (4 * (6 - f)));
      @(negedge ref_clk);
      cs = '0;
   endtask : pls
   function automatic logic exp_irq(input logic [7:0] mk, input logic [7:0] s);
      return !(gen && |(mk & s));
   endfunction : exp_irq
   // =====
   // main sequence
   initial
   begin
      repeat (3) @(negedge ref_clk);
      nrst = 1'b1;
      rx(8'h01, 8'h80);
      xf(1'b1, 8'h02, 8'hFF);
      rx(8'h02, 8'h00);
      m = 8'($random(seed));
      xf(1'b1, 8'h01, m);
      rx(8'h01, m);
      $display("test registers done");
      for (int i = 0; i < 3; i++)
      begin
         gen = (i != 2);
         m = 8'(i != 1);
         xf(1'b1, 8'h01, m);
         b = 4'($random(seed)) | 4'h1;
         pls(0, b);
         chk("irq_n", 8'(exp_irq(m, 8'h01)), 8'(irq_n));
         rx(8'h00, 8'h01);
         rx(8'h02, {4'h0, b});
         rx(8'h03, {4'h0, b});
         rx(8'h02, 8'h00);
         chk("irq_n", 8'h01, 8'(irq_n));
      end
      $display("test power events done");
      fp = 2'b11;
      ss = 2'b01;
      pls(1, 4'h1);
      rx(8'h02, 8'h00);
      pls(1, 4'h2);
      rx(8'h03, 8'h30);
      pls(0, 4'h1);
      rx(8'h03, 8'h01);
      pls(1, 4'h4);
      rx(8'h03, 8'h40);
      fp = 2'b00;
      $display("test four-pair done");
      pls(2, 4'h4);
      rx(8'h04, 8'h04);
      pls(4, 4'h8);
      rx(8'h04, 8'h84);
      pls(6, 4'h4);
      rx(8'h05, 8'h80);
      rx(8'h04, 8'h00);
      cce = 1'b1;
      dce = 1'b1;
      pls(4, 4'h1);
      pls(2, 4'h2);
      rx(8'h04, 8'h00);
      pls(5, 4'h1);
      pls(3, 4'h2);
      rx(8'h04, 8'h12);
      flt = 4'($random(seed));
      rx(8'h00, {flt[3:1], 2'b11, flt[0], 2'b00});
      clr = 1'b1;
      @(negedge ref_clk);
      clr = 1'b0;
      rx(8'h04, 8'h00);
      $display("test discovery done");
      end_sim();
   end
endmodule : tb
